// *** design/sws_session.sv ***
// Session and framing layer of the single-wire link, device side.
// Contract
// - Sleep flag sleeps and resets engine, buffer.
// - Sleep flag honoured wherever flags are accepted.
// - Count byte counts all bytes, four to 39.
// - CRC-16 poly 8005, zero start, count and packet.
// - Checksum low byte first, high byte last.
// - Transmit after wake returns status 11.
// - Bad format answers error; busy ignores transmit.
// - Token must complete within IO timeout.
// - Illegal long low pulse leads to sleep.
// - Timeout armed through block, restarted per token.
// - Timeout armed at wake; idle wake sleeps.
// - Timeout disabled while executing.
// - Asleep, any bit wakes; wake-delay bits ignored.
// - Watchdog from wake forces sleep anywhere.
// - Watchdog cleared only by sleep then wake.
// - Flags 66 command, 99 transmit, CC sleep.
// - Status block: count, code, two CRC bytes.
// - Bytes in order, bits least significant first.
`timescale 1ns/1ns
`default_nettype none
module sws_session
   import sws_pkg::*;
#(
   parameter int unsigned IO_TIMEOUT_CYC = IO_TIMEOUT_CYCLES,
   parameter int unsigned WDOG_CYC       = WATCHDOG_CYCLES,
   parameter int unsigned EXEC_CYC       = EXECUTION_DELAY_CYCLES
) (
   // Clock and reset.
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   // Token decoder.
   input  wire logic        i_token_start,
   input  wire logic        i_bit_valid,
   input  wire logic        i_bit_value,
   input  wire logic        i_illegal_token,
   // Bit serialiser toward the wire.
   output logic             o_tx_valid,
   output logic             o_tx_bit,
   input  wire logic        i_tx_ready,
   // Command engine.
   output logic [7:0]       o_rx_byte,
   output logic             o_rx_byte_valid,
   output logic             o_cmd_go,
   output logic             o_engine_reset,
   input  wire logic        i_exec_done,
   input  wire logic        i_exec_error,
   input  wire logic [7:0]  i_result_byte,
   // Power state.
   output logic             o_sleep
);

   sws_state_type state;
   sws_state_type next_state;
   sws_resp_type  resp_kind;
   logic [2:0]    bit_cnt;
   logic [7:0]    shift;
   logic [7:0]    rx_next;
   logic          byte_done;
   logic          accepting;
   logic [5:0]    byte_idx;
   logic [5:0]    blk_count;
   logic [7:0]    crc_lo;
   logic          blk_bad;
   logic [31:0]   wake_cnt;
   logic [31:0]   wdog_cnt;
   logic [31:0]   io_cnt;
   logic [31:0]   busy_cnt;
   logic          first_pending;
   logic          token_open;
   logic          illegal_seen;
   logic          io_armed;
   logic          io_expire;
   logic          wdog_expire;
   logic          exec_ok;
   logic [7:0]    result;
   logic [1:0]    tx_idx;
   logic [2:0]    tx_bit;
   logic [7:0]    tx_shift;
   logic          tx_step;
   logic          tx_last;
   logic          crc_clear;
   logic          crc_feed;
   logic [7:0]    crc_byte;
   logic [15:0]   crc;

   // Byte assembly from legal tokens, least significant bit first.
   assign accepting = (state == ST_IDLE) || (state == ST_RX_BLOCK);
   assign byte_done = accepting && i_bit_valid && (bit_cnt == 3'd7);
   assign rx_next   = {i_bit_value, shift[7:1]};

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || !accepting || next_state == ST_SLEEP) begin
         bit_cnt <= 3'd0;
         shift   <= 8'h00;
      end else if (i_bit_valid) begin
         bit_cnt <= bit_cnt + 3'd1;
         shift   <= rx_next;
      end
   end

   // Wake delay, watchdog and busy interval counters.
   assign wdog_expire = (state != ST_SLEEP) && (wdog_cnt >= WDOG_CYC - 1);

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || state == ST_SLEEP || next_state == ST_SLEEP) begin
         wdog_cnt <= 32'h0000_0000;
      end else begin
         wdog_cnt <= wdog_cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || state != ST_WAKING) begin
         wake_cnt <= 32'h0000_0000;
      end else begin
         wake_cnt <= wake_cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || state != next_state) begin
         busy_cnt <= 32'h0000_0000;
      end else begin
         busy_cnt <= busy_cnt + 32'h0000_0001;
      end
   end

   // IO timeout: armed at wake, inside a token or byte, and through the block.
   assign io_armed  = ((state == ST_IDLE) &&
                       (first_pending || token_open || illegal_seen || bit_cnt != 3'd0)) ||
                      (state == ST_RX_BLOCK);
   assign io_expire = io_armed && (io_cnt >= IO_TIMEOUT_CYC - 1);

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || !io_armed) begin
         io_cnt <= 32'h0000_0000;
      end else if (i_bit_valid && !illegal_seen) begin
         io_cnt <= 32'h0000_0000;
      end else begin
         io_cnt <= io_cnt + 32'h0000_0001;
      end
   end

   // Token tracking; an illegal token blocks the per-token restart of the timeout until sleep.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || state == ST_SLEEP || state == ST_WAKING) begin
         first_pending <= (state == ST_WAKING) && !i_reset;
         token_open    <= 1'b0;
         illegal_seen  <= 1'b0;
      end else if (accepting) begin
         if (i_token_start || i_bit_valid) begin
            first_pending <= 1'b0;
         end
         token_open <= i_token_start || (token_open && !i_bit_valid);
         if (i_illegal_token) begin
            illegal_seen <= 1'b1;
         end
      end
   end

   // Session sequencing.
   always_comb begin
      next_state = state;
      case (state)
         ST_SLEEP: begin
            if (i_token_start || i_bit_valid) begin
               next_state = ST_WAKING;
            end
         end
         ST_WAKING: begin
            if (wake_cnt >= WAKE_DELAY_CYCLES - 1) begin
               next_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (byte_done) begin
               case (rx_next)
                  FLAG_SLEEP:    next_state = ST_SLEEP;
                  FLAG_COMMAND:  next_state = ST_RX_BLOCK;
                  FLAG_TRANSMIT: begin
                     if (resp_kind != RESP_NONE) begin
                        next_state = ST_TX;
                     end
                  end
                  default:       next_state = ST_IDLE;
               endcase
            end
         end
         ST_RX_BLOCK: begin
            if (byte_done && ((byte_idx == 6'd0) ?
                (rx_next[7:6] != 2'b00 || rx_next[5:0] < BLOCK_COUNT_MIN ||
                 rx_next[5:0] > BLOCK_COUNT_MAX) : (byte_idx == blk_count - 6'd1))) begin
               next_state = ST_PARSE;
            end
         end
         ST_PARSE: begin
            if (busy_cnt >= PARSE_DELAY_CYCLES - 1) begin
               next_state = blk_bad ? ST_IDLE : ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (busy_cnt >= EXEC_CYC - 1) begin
               next_state = ST_IDLE;
            end
         end
         ST_TX: begin
            if (tx_last) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_SLEEP;
      endcase
      if ((io_expire || wdog_expire) && state != ST_SLEEP) begin
         next_state = ST_SLEEP;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         state <= ST_SLEEP;
      end else begin
         state <= next_state;
      end
   end

   // Engine reset on every entry into sleep; sleep output follows the state.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_engine_reset <= 1'b1;
      end else begin
         o_engine_reset <= (next_state == ST_SLEEP) && (state != ST_SLEEP);
      end
   end
   assign o_sleep = (state == ST_SLEEP);

   // Block reception: count, packet forwarding and checksum comparison.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || state != ST_RX_BLOCK) begin
         byte_idx        <= 6'd0;
         o_rx_byte_valid <= 1'b0;
         if (state != ST_PARSE) begin
            blk_bad <= 1'b0;
         end
      end else begin
         o_rx_byte_valid <= 1'b0;
         if (byte_done) begin
            byte_idx <= byte_idx + 6'd1;
            if (byte_idx == 6'd0) begin
               blk_count <= rx_next[5:0];
               blk_bad   <= (next_state == ST_PARSE);
            end else if (byte_idx == blk_count - 6'd2) begin
               crc_lo <= rx_next;
            end else if (byte_idx == blk_count - 6'd1) begin
               blk_bad <= ({rx_next, crc_lo} != crc);
            end else begin
               o_rx_byte       <= rx_next;
               o_rx_byte_valid <= 1'b1;
            end
         end
      end
   end

   // Start pulse to the engine and capture of its outcome.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || state == ST_SLEEP) begin
         o_cmd_go <= 1'b0;
         exec_ok  <= 1'b0;
         result   <= 8'h00;
      end else begin
         o_cmd_go <= (state == ST_PARSE) && (next_state == ST_EXEC);
         if (o_cmd_go) begin
            exec_ok <= 1'b0;
         end else if (state == ST_EXEC && i_exec_done) begin
            exec_ok <= !i_exec_error;
            result  <= i_result_byte;
         end
      end
   end

   // What the next transmit flag returns.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || state == ST_SLEEP) begin
         resp_kind <= RESP_WAKE;
      end else if (state == ST_IDLE && next_state == ST_RX_BLOCK) begin
         resp_kind <= RESP_NONE;
      end else if (state == ST_PARSE && next_state == ST_IDLE) begin
         resp_kind <= RESP_COMM;
      end else if (state == ST_EXEC && next_state == ST_IDLE) begin
         resp_kind <= exec_ok ? RESP_RESULT : RESP_EXEC;
      end
   end

   // Response block serialiser: count, code, checksum low, checksum high.
   assign tx_step = (state == ST_TX) && i_tx_ready;
   assign tx_last = tx_step && (tx_idx == 2'd3) && (tx_bit == 3'd7);

   always_ff @(posedge i_clk_sys) begin
      if (i_reset || state == ST_SLEEP) begin
         tx_idx   <= 2'd0;
         tx_bit   <= 3'd0;
         tx_shift <= 8'h00;
      end else if (state == ST_IDLE && next_state == ST_TX) begin
         tx_idx   <= 2'd0;
         tx_bit   <= 3'd0;
         tx_shift <= STATUS_BLOCK_COUNT;
      end else if (tx_step) begin
         tx_bit <= tx_bit + 3'd1;
         if (tx_bit == 3'd7) begin
            tx_idx <= tx_idx + 2'd1;
            case (tx_idx)
               2'd0: begin
                  case (resp_kind)
                     RESP_WAKE:   tx_shift <= STATUS_WAKE_OK;
                     RESP_COMM:   tx_shift <= STATUS_COMM_ERROR;
                     RESP_EXEC:   tx_shift <= STATUS_EXEC_ERROR;
                     default:     tx_shift <= result;
                  endcase
               end
               2'd1:    tx_shift <= crc[7:0];
               default: tx_shift <= crc[15:8];
            endcase
         end else begin
            tx_shift <= {1'b0, tx_shift[7:1]};
         end
      end
   end
   assign o_tx_valid = (state == ST_TX);
   assign o_tx_bit   = tx_shift[0];

   // Shared checksum: restarted by a command or transmit flag, fed per byte.
   assign crc_clear = (state == ST_IDLE) &&
                      (next_state == ST_RX_BLOCK || next_state == ST_TX);
   assign crc_feed  = (byte_done && state == ST_RX_BLOCK &&
                       (byte_idx == 6'd0 || byte_idx < blk_count - 6'd2)) ||
                      (state == ST_TX && tx_bit == 3'd0 && tx_idx < 2'd2 && tx_step);
   assign crc_byte  = (state == ST_TX) ? tx_shift : rx_next;

   sws_crc16 u_crc (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_clear   (crc_clear),
      .i_feed    (crc_feed),
      .i_byte    (crc_byte),
      .o_crc     (crc)
   );

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   sequence s_flag_sleep;
      state == ST_IDLE && byte_done && rx_next == FLAG_SLEEP;
   endsequence

   sequence s_enter_sleep;
      state != ST_SLEEP ##1 state == ST_SLEEP;
   endsequence

   chk_sleep_flag_honoured: assert property (s_flag_sleep |=> o_sleep && o_engine_reset)
      else $error("Sleep flag did not put the session to sleep.");

   chk_sleep_resets_engine: assert property (s_enter_sleep |-> o_engine_reset && bit_cnt == 3'd0)
      else $error("Entry into sleep without engine reset.");

   chk_wake_status_code: assert property (
      state == ST_TX && resp_kind == RESP_WAKE && tx_idx == 2'd1 && tx_bit == 3'd0
      |-> tx_shift == 8'h11)
      else $error("Wake status code not returned.");

   chk_bad_block_error: assert property (
      state == ST_PARSE && blk_bad && busy_cnt == PARSE_DELAY_CYCLES - 1 && !wdog_expire
      |=> state == ST_IDLE && resp_kind == RESP_COMM)
      else $error("Malformed block not answered with communication error.");

   chk_busy_no_transmit: assert property (
      state == ST_EXEC ##1 state == ST_EXEC |-> !o_tx_valid && io_cnt == 32'h0000_0000)
      else $error("Activity during execution.");

   chk_io_timeout_sleep: assert property (io_expire |=> o_sleep ##1 o_sleep || state == ST_WAKING)
      else $error("IO timeout did not force sleep.");

   chk_io_token_restart: assert property (
      state == ST_RX_BLOCK && i_bit_valid && !illegal_seen && next_state == ST_RX_BLOCK
      |=> io_cnt == 32'h0000_0000)
      else $error("Legal token did not restart the IO timeout.");

   chk_wdog_forces_sleep: assert property (wdog_expire |=> o_sleep && wdog_cnt == 32'h0000_0000)
      else $error("Watchdog expiry did not force sleep.");

   chk_wdog_no_restart: assert property (
      state != ST_SLEEP ##1 state != ST_SLEEP |-> wdog_cnt == $past(wdog_cnt) + 32'h0000_0001)
      else $error("Watchdog counter restarted while awake.");

   chk_wake_bits_ignored: assert property (
      state == ST_WAKING && i_bit_valid |=> bit_cnt == 3'd0)
      else $error("Bit taken during wake delay.");

   chk_count_out_range: assert property (
      state == ST_RX_BLOCK && byte_done && byte_idx == 6'd0 && rx_next > 8'h27 && !io_expire &&
      !wdog_expire |=> state == ST_PARSE && blk_bad)
      else $error("Out of range count not flagged.");

   chk_crc_high_last: assert property (
      state == ST_TX && tx_idx == 2'd3 && tx_bit == 3'd0 |-> tx_shift == crc[15:8])
      else $error("Last response byte is not the checksum high byte.");

endmodule : sws_session
`default_nettype wire

// *** design/sws_pkg.sv ***
// Constants, timing counts and types shared by the single-wire session layer.
package sws_pkg;

   // System clock rate used to turn times into cycle counts.
   localparam int unsigned CLK_MHZ                = 25;

   // Interval lengths in microseconds, and the cycle counts derived from them.
   localparam int unsigned PARSE_DELAY_US         = 100;
   localparam int unsigned PARSE_DELAY_CYCLES     = PARSE_DELAY_US * CLK_MHZ;
   localparam int unsigned EXECUTION_DELAY_US     = 13000;
   localparam int unsigned EXECUTION_DELAY_CYCLES = EXECUTION_DELAY_US * CLK_MHZ;
   localparam int unsigned IO_TIMEOUT_INTERVAL_US = 20000;
   localparam int unsigned IO_TIMEOUT_CYCLES      = IO_TIMEOUT_INTERVAL_US * CLK_MHZ;
   localparam int unsigned WAKE_DELAY_US          = 100;
   localparam int unsigned WAKE_DELAY_CYCLES      = WAKE_DELAY_US * CLK_MHZ;
   localparam int unsigned WATCHDOG_US            = 1700000;
   localparam int unsigned WATCHDOG_CYCLES        = WATCHDOG_US * CLK_MHZ;

   // Flag byte encodings.
   localparam logic [7:0]  FLAG_COMMAND           = 8'h66;
   localparam logic [7:0]  FLAG_TRANSMIT          = 8'h99;
   localparam logic [7:0]  FLAG_SLEEP             = 8'hCC;

   // Status codes and the size of a status block.
   localparam logic [7:0]  STATUS_WAKE_OK         = 8'h11;
   localparam logic [7:0]  STATUS_EXEC_ERROR      = 8'h0F;
   localparam logic [7:0]  STATUS_COMM_ERROR      = 8'hFF;
   localparam logic [7:0]  STATUS_BLOCK_COUNT     = 8'h04;

   // Legal block count range.
   localparam logic [5:0]  BLOCK_COUNT_MIN        = 6'h04;
   localparam logic [5:0]  BLOCK_COUNT_MAX        = 6'h27;

   // Checksum polynomial and start value.
   localparam logic [15:0] CRC_POLY               = 16'h8005;
   localparam logic [15:0] CRC_INIT               = 16'h0000;

   // Session states.
   typedef enum logic [2:0] {
      ST_SLEEP,
      ST_WAKING,
      ST_IDLE,
      ST_RX_BLOCK,
      ST_PARSE,
      ST_EXEC,
      ST_TX
   } sws_state_type;

   // What a transmit flag would currently return.
   typedef enum logic [2:0] {
      RESP_NONE,
      RESP_WAKE,
      RESP_COMM,
      RESP_EXEC,
      RESP_RESULT
   } sws_resp_type;

endpackage : sws_pkg

// *** design/sws_crc16.sv ***
// Byte-wide CRC-16 accumulator for the block checksum.
`timescale 1ns/1ns
`default_nettype none
module sws_crc16
   import sws_pkg::*;
(
   // Clock and reset.
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   // Control and data.
   input  wire logic        i_clear,
   input  wire logic        i_feed,
   input  wire logic [7:0]  i_byte,
   // Running checksum.
   output logic [15:0]      o_crc
);

   // Folds one byte in, least significant bit first, as the bits travel on the wire.
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         if (data[i] != c[15]) begin
            c = {c[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction : crc_step

   // Clear restarts from zero; a feed folds in the offered byte.
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || i_clear) begin
         o_crc <= CRC_INIT;
      end else if (i_feed) begin
         o_crc <= crc_step(o_crc, i_byte);
      end
   end

   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   chk_crc_clear_zero: assert property (i_clear |=> o_crc == 16'h0000)
      else $error("Checksum not zero after clear.");

   chk_crc_hold_idle: assert property (!i_clear && !i_feed |=> $stable(o_crc))
      else $error("Checksum changed without a feed.");

endmodule : sws_crc16
`default_nettype wire

// *** tb/sws_host_model.sv ***
// Host controller model that sends tokens and bytes toward the session layer.
`timescale 1ns/1ns
`default_nettype none
module sws_host_model (
   // Clock.
   input  wire logic i_clk_sys,
   // Token decoder side.
   output logic      o_token_start,
   output logic      o_bit_valid,
   output logic      o_bit_value,
   output logic      o_illegal_token
);
   // Idle line at time zero.
   initial begin
      o_token_start   = 1'b0;
      o_bit_valid     = 1'b0;
      o_bit_value     = 1'b0;
      o_illegal_token = 1'b0;
   end

   // One token: leading edge, then the completed bit; the value is scrambled after.
   task automatic send_bit(input logic b);
      @(posedge i_clk_sys);
      o_token_start <= 1'b1;
      @(posedge i_clk_sys);
      o_token_start <= 1'b0;
      o_bit_valid   <= 1'b1;
      o_bit_value   <= b;
      @(posedge i_clk_sys);
      o_bit_valid   <= 1'b0;
      o_bit_value   <= ~b;
   endtask : send_bit

   // A byte goes out least significant bit first.
   task automatic send_byte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         send_bit(v[i]);
      end
   endtask : send_byte

   // A low pulse that overruns the zero-bit low time.
   task automatic send_illegal();
      @(posedge i_clk_sys);
      o_illegal_token <= 1'b1;
      @(posedge i_clk_sys);
      o_illegal_token <= 1'b0;
   endtask : send_illegal
endmodule : sws_host_model
`default_nettype wire

// *** tb/tb_sws_session.sv ***
// Self-checking testbench of the single-wire session layer.
`timescale 1ns/1ns
`default_nettype none
module tb_sws_session;
   import sws_pkg::*;
   localparam int unsigned IO_TO = 200;
   localparam int unsigned WD    = 9000;
   localparam int unsigned EX    = 100;
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   logic tok, bv, bval, ill, tx_v, tx_b, rx_v, go, eng_rst, slp;
   logic tx_rdy = 1'b1;
   logic done = 1'b0;
   logic err = 1'b0;
   logic [7:0] rx_b;
   logic [7:0] res = 8'h00;
   logic [7:0] sh = 8'h00;
   logic [31:0] lfsr = 32'hdc5d_466e;
   logic [7:0] rxq[$];
   logic [7:0] txq[$];
   int n_mismatch = 0;
   int samples_checked = 0;
   int nb = 0;
   int dcnt = 0;
   int n_go = 0;

   always #20 i_clk_sys = ~i_clk_sys;

   sws_host_model host (.i_clk_sys(i_clk_sys), .o_token_start(tok), .o_bit_valid(bv),
      .o_bit_value(bval), .o_illegal_token(ill));

   sws_session #(.IO_TIMEOUT_CYC(IO_TO), .WDOG_CYC(WD), .EXEC_CYC(EX)) dut (
      .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_token_start(tok), .i_bit_valid(bv),
      .i_bit_value(bval), .i_illegal_token(ill), .o_tx_valid(tx_v), .o_tx_bit(tx_b),
      .i_tx_ready(tx_rdy), .o_rx_byte(rx_b), .o_rx_byte_valid(rx_v), .o_cmd_go(go),
      .o_engine_reset(eng_rst), .i_exec_done(done), .i_exec_error(err),
      .i_result_byte(res), .o_sleep(slp));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // Bitwise checksum, bits least significant first into a top-bit feedback register.
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (b[i]) begin
         for (int k = 0; k < 8; k++) begin
            c = (c[15] ^ b[i][k]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
         end
      end
      return c;
   endfunction : crc16

   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_byte

   task automatic chk_flag(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_flag

   task automatic stop_test();
      $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   // Random serialiser stalls, and an engine that answers ten cycles after the start pulse.
   always @(posedge i_clk_sys) begin
      lfsr <= lfsr_next(lfsr);
      tx_rdy <= lfsr[0] | lfsr[1];
      done <= (dcnt == 1);
      dcnt <= (go === 1'b1) ? 10 : ((dcnt > 0) ? dcnt - 1 : 0);
      if (dcnt == 1) begin
         res <= lfsr[15:8];
      end
      if (go === 1'b1) begin
         n_go <= n_go + 1;
      end
   end

   // Watchers take the oldest note whenever a byte appears.
   always @(posedge i_clk_sys) begin
      if (rx_v === 1'b1) begin
         chk_byte("rx_byte", rxq.size() > 0 ? rxq.pop_front() : 8'hxx, rx_b);
      end
      if (tx_v === 1'b1 && tx_rdy === 1'b1) begin
         sh = {tx_b, sh[7:1]};
         nb++;
         if (nb == 8) begin
            nb = 0;
            chk_byte("tx_byte", txq.size() > 0 ? txq.pop_front() : 8'hxx, sh);
         end
      end
   end

   // Bounded wait for sleep no earlier than lo cycles.
   task automatic wait_sleep(input int lo, input int hi);
      int n;
      n = 0;
      #1;
      while (slp !== 1'b1 && n < hi) begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      chk_flag("sleep", 1'b1, slp);
      chk_flag("engine_reset", 1'b1, eng_rst);
      chk_flag("sleep_early", 1'b1, n >= lo);
      if (slp !== 1'b1) stop_test();
   endtask : wait_sleep

   // Wake token, then a byte inside the wake-up delay that must be dropped.
   task automatic wake();
      host.send_bit(1'b0);
      host.send_byte(FLAG_SLEEP);
      repeat (2480) @(posedge i_clk_sys);
   endtask : wake

   // Transmit flag with the expected status or result block noted first.
   task automatic send_tx(input logic [7:0] code);
      logic [7:0] b[$];
      logic [15:0] c;
      int n;
      b.push_back(STATUS_BLOCK_COUNT);
      b.push_back(code);
      c = crc16(b);
      txq.push_back(STATUS_BLOCK_COUNT);
      txq.push_back(code);
      txq.push_back(c[7:0]);
      txq.push_back(c[15:8]);
      host.send_byte(FLAG_TRANSMIT);
      n = 0;
      while (txq.size() > 0 && n < 400) begin
         @(posedge i_clk_sys);
         n++;
      end
      chk_flag("response_done", 1'b1, txq.size() == 0);
      if (txq.size() > 0) stop_test();
   endtask : send_tx

   // Command block of len packet bytes; bad flips the checksum.
   task automatic send_blk(input int len, input logic bad);
      logic [7:0] b[$];
      logic [15:0] c;
      b.push_back(8'(len + 3));
      for (int i = 0; i < len; i++) begin
         b.push_back(lfsr[7:0] ^ 8'(i * 37));
         rxq.push_back(b[i + 1]);
      end
      c = crc16(b);
      b.push_back(c[7:0]);
      b.push_back(c[15:8] ^ {7'h00, bad});
      host.send_byte(FLAG_COMMAND);
      foreach (b[i]) host.send_byte(b[i]);
   endtask : send_blk

   initial begin
      repeat (100000) @(posedge i_clk_sys);
      n_mismatch++;
      stop_test();
   end

   initial begin
      repeat (8) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      wake();
      send_tx(STATUS_WAKE_OK);
      send_blk(1, 1'b1);
      repeat (2600) @(posedge i_clk_sys);
      send_tx(STATUS_COMM_ERROR);
      host.send_byte(FLAG_COMMAND);
      host.send_byte(8'h30);
      repeat (2600) @(posedge i_clk_sys);
      send_tx(STATUS_COMM_ERROR);
      host.send_byte(FLAG_SLEEP);
      wait_sleep(0, 40);
      wake();
      send_blk(36, 1'b0);
      repeat (2520) @(posedge i_clk_sys);
      host.send_byte(FLAG_TRANSMIT);
      repeat (200) @(posedge i_clk_sys);
      chk_byte("cmd_go_count", 8'h01, 8'(n_go));
      send_tx(res);
      send_tx(res);
      host.send_byte(FLAG_SLEEP);
      wait_sleep(0, 40);
      wake();
      wait_sleep(150, 260);
      wake();
      repeat (3) host.send_bit(1'b1);
      wait_sleep(150, 260);
      wake();
      host.send_byte(8'h00);
      host.send_illegal();
      wait_sleep(150, 260);
      wake();
      err <= 1'b1;
      host.send_byte(8'h00);
      send_blk(1, 1'b0);
      repeat (2600) @(posedge i_clk_sys);
      send_tx(STATUS_EXEC_ERROR);
      repeat (3200) @(posedge i_clk_sys);
      chk_flag("awake", 1'b0, slp);
      wait_sleep(300, 700);
      repeat (2 * IO_TO) @(posedge i_clk_sys);
      wake();
      send_tx(STATUS_WAKE_OK);
      stop_test();
   end
endmodule : tb_sws_session
`default_nettype wire
